// file: design/clcr_bank.sv
/*
  Charger limit control register bank: three read/write configuration
  bytes, their decoded settings and the watchdog that guards 04h and 05h.
  Assumes the serial front end presents byte accesses on this clock:
  a one-cycle write strobe, and a read address whose data is registered.
*/
`timescale 1ns/1ns
module clcr_bank #(
  parameter longint WDOG_BASE_CYC = clcr_pkg::WDOG_BASE_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // Register access
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        reg_rst_i,
  input  wire logic        wdog_kick_i,
  output logic      [7:0]  rdata_o,
  output logic             rvalid_o,
  output logic             wdog_expired_o,
  // Decoded settings
  output logic      [12:0] charge_voltage_mv_o,
  output logic      [12:0] warm_voltage_mv_o,
  output logic      [5:0]  final_phase_min_o,
  output logic      [7:0]  recharge_margin_mv_o,
  output logic             term_en_o,
  output logic             timer_en_o,
  output logic      [4:0]  pre_phase_h_o,
  output logic      [4:0]  fast_phase_h_o,
  output logic      [6:0]  thermal_limit_c_o,
  output logic      [13:0] input_overvoltage_mv_o,
  output logic      [1:0]  boost_output_voltage_code_o,
  output logic      [12:0] input_floor_mv_o
);
  // All checks of this module share the one clock and stay quiet in reset
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] ofs_to_idx(input logic [7:0] a);
    return 2'(a - clcr_pkg::OFS_CHARGE_VOLTAGE_LIMIT);
  endfunction : ofs_to_idx

  function automatic logic mapped(input logic [7:0] a);
    return a >= clcr_pkg::OFS_CHARGE_VOLTAGE_LIMIT &&
           a <= clcr_pkg::OFS_INPUT_BOOST_THRESHOLDS;
  endfunction : mapped

  // Listed low codes are not evenly spaced, so a table holds them
  function automatic logic [12:0] vcode_mv(input logic [4:0] c);
    logic [12:0] mv;
    mv = 13'd0;
    unique case (c)
      5'h00: mv = 13'd3494;
      5'h01: mv = 13'd3590;
      5'h02: mv = 13'd3686;
      5'h03: mv = 13'd3790;
      5'h04: mv = 13'd3894;
      5'h05: mv = 13'd3990;
      5'h06: mv = 13'd4090;
      5'h07: mv = 13'd4140;
      5'h08: mv = 13'd4190;
      default: mv = clcr_pkg::VLINEAR_BASE_MV + clcr_pkg::VSTEP_MV *
                    13'(c - clcr_pkg::VCODE_LINEAR_FIRST); // see [R2]
    endcase
    return mv; // see [R1]
  endfunction : vcode_mv

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  clcr_bus_if bus ();

  clcr_store u_store (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .bus       (bus.store)
  );

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  logic [34:0] wdog_cnt_q, wdog_cnt_d;
  logic        wdog_exp_q, wdog_exp_d;
  logic [34:0] wdog_limit;
  logic [1:0]  wdog_sel;

  assign wdog_sel = bus.reg_q[1][clcr_pkg::WDOG_LSB +: 2];

  always_comb begin
    unique case (wdog_sel) // see [R9]
      2'b00: wdog_limit = '0;
      2'b01: wdog_limit = 35'(WDOG_BASE_CYC);
      2'b10: wdog_limit = 35'(WDOG_BASE_CYC * 2);
      2'b11: wdog_limit = 35'(WDOG_BASE_CYC * 4);
    endcase
  end

  // Any register write or explicit kick restarts the period
  always_comb begin
    wdog_cnt_d = wdog_cnt_q + 35'd1;
    wdog_exp_d = 1'b0;
    if (wdog_sel == 2'b00 || wr_i || wdog_kick_i || reg_rst_i) begin
      wdog_cnt_d = '0;
    end else if (wdog_cnt_q >= wdog_limit - 35'd1) begin
      wdog_cnt_d = '0;
      wdog_exp_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wdog_cnt_q <= '0;
      wdog_exp_q <= 1'b0;
    end else begin
      wdog_cnt_q <= wdog_cnt_d;
      wdog_exp_q <= wdog_exp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------------
  // Expiry restores 04h and 05h on the next edge; a write to them landing then is overridden
  assign bus.wr_en    = wr_i && mapped(addr_i);
  assign bus.wr_idx   = ofs_to_idx(addr_i);
  assign bus.wr_data  = wdata_i;
  assign bus.rst_cmd  = reg_rst_i;
  assign bus.wdog_rst = wdog_exp_q;

  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_d;

  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = rd_i;
    if (rd_i) begin
      rdata_d = mapped(addr_i) ? bus.reg_q[ofs_to_idx(addr_i)]
                               : clcr_pkg::UNMAPPED_READ;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rdata_q  <= '0;
    end else begin
      rdata_q  <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Settings decode
  // ----------------------------------------------------------------------
  logic [7:0]  r4, r5, r6;
  logic [12:0] cv_d, wv_d, fl_d;
  logic [5:0]  fp_d;
  logic [7:0]  rm_d;
  logic [4:0]  fh_d, ph_d;
  logic [6:0]  th_d;
  logic [13:0] ov_d;

  assign r4 = bus.reg_q[0];
  assign r5 = bus.reg_q[1];
  assign r6 = bus.reg_q[2];

  always_comb begin
    cv_d = vcode_mv(r4[clcr_pkg::VCODE_LSB +: 5]); // see [R1]
    // Warm band never raises the target, it only caps it
    wv_d = (r5[clcr_pkg::WARM_BIT] || cv_d < clcr_pkg::WARM_CAP_MV) ?
           cv_d : clcr_pkg::WARM_CAP_MV; // see [R13]
    fp_d = clcr_pkg::FINAL_STEP_MIN *
           6'(r4[clcr_pkg::FINAL_LSB +: 2]); // see [R3]
    rm_d = r4[clcr_pkg::RECHG_BIT] ? clcr_pkg::RECHG_HI_MV
                                   : clcr_pkg::RECHG_LO_MV; // see [R4]
    ph_d = r5[clcr_pkg::TIMER_EN_BIT] ? clcr_pkg::PRE_H : 5'd0; // see [R10]
    fh_d = !r5[clcr_pkg::TIMER_EN_BIT] ? 5'd0 :
           r5[clcr_pkg::FAST_DUR_BIT] ? clcr_pkg::FAST_SHORT_H
                                      : clcr_pkg::FAST_LONG_H; // see [R11]
    th_d = r5[clcr_pkg::THERM_BIT] ? clcr_pkg::THERM_HI_C
                                   : clcr_pkg::THERM_LO_C; // see [R12]
    unique case (r6[clcr_pkg::OVP_LSB +: 2]) // see [R14]
      2'b00: ov_d = clcr_pkg::OVP_MV_00;
      2'b01: ov_d = clcr_pkg::OVP_MV_01;
      2'b10: ov_d = clcr_pkg::OVP_MV_10;
      2'b11: ov_d = clcr_pkg::OVP_MV_11;
    endcase
    fl_d = clcr_pkg::FLOOR_BASE_MV + clcr_pkg::FLOOR_STEP_MV *
           13'(r6[clcr_pkg::FLOOR_LSB +: 4]); // see [R16] see [R17]
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      charge_voltage_mv_o         <= '0;
      warm_voltage_mv_o           <= '0;
      final_phase_min_o           <= '0;
      recharge_margin_mv_o        <= '0;
      term_en_o                   <= 1'b0;
      timer_en_o                  <= 1'b0;
      pre_phase_h_o               <= '0;
      fast_phase_h_o              <= '0;
      thermal_limit_c_o           <= '0;
      input_overvoltage_mv_o      <= '0;
      boost_output_voltage_code_o <= '0;
      input_floor_mv_o            <= '0;
      rdata_o                     <= '0;
      rvalid_o                    <= 1'b0;
      wdog_expired_o              <= 1'b0;
    end else begin
      charge_voltage_mv_o         <= cv_d;
      warm_voltage_mv_o           <= wv_d;
      final_phase_min_o           <= fp_d;
      recharge_margin_mv_o        <= rm_d;
      term_en_o                   <= r5[clcr_pkg::TERM_EN_BIT]; // see [R8]
      timer_en_o                  <= r5[clcr_pkg::TIMER_EN_BIT];
      pre_phase_h_o               <= ph_d;
      fast_phase_h_o              <= fh_d;
      thermal_limit_c_o           <= th_d;
      input_overvoltage_mv_o      <= ov_d;
      boost_output_voltage_code_o <= r6[clcr_pkg::BOOST_LSB +: 2]; // see [R15]
      input_floor_mv_o            <= fl_d;
      rdata_o                     <= rdata_d;
      rvalid_o                    <= rvalid_d;
      wdog_expired_o              <= wdog_exp_q;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_write_06;
    wr_i && addr_i == clcr_pkg::OFS_INPUT_BOOST_THRESHOLDS && !reg_rst_i;
  endsequence

  // A restore in the same cycle beats the write, so it is left out
  sequence s_plain_write;
    wr_i && !reg_rst_i && !wdog_exp_q;
  endsequence

  // Decoded outputs read zero at release, hence nrst_i in some antecedents
  a_cmd_restore_04: assert property ( // see [R5]
    reg_rst_i |=> r4 == clcr_pkg::RST_CHARGE_VOLTAGE_LIMIT)
    else $error("04h not restored by reset command");
  a_cmd_restore_06: assert property ( // see [R7]
    reg_rst_i |=> r6 == clcr_pkg::RST_INPUT_BOOST_THRESHOLDS)
    else $error("06h not restored by reset command");
  a_wdog_restore_04: assert property ( // see [R5]
    wdog_exp_q |=> r4 == clcr_pkg::RST_CHARGE_VOLTAGE_LIMIT)
    else $error("04h not restored by watchdog");
  a_wdog_restore_05: assert property ( // see [R6]
    wdog_exp_q |=> r5 == clcr_pkg::RST_CHARGER_CONTROL_TIMERS)
    else $error("05h not restored by watchdog");
  a_write_lands_04: assert property ( // see [R5]
    s_plain_write ##0 addr_i == clcr_pkg::OFS_CHARGE_VOLTAGE_LIMIT
      |=> r4 == $past(wdata_i))
    else $error("04h write lost");
  a_write_lands_05: assert property ( // see [R6]
    s_plain_write ##0 addr_i == clcr_pkg::OFS_CHARGER_CONTROL_TIMERS
      |=> r5 == $past(wdata_i))
    else $error("05h write lost");
  a_write_read_06: assert property ( // see [R7]
    s_write_06 ##1 rd_i && addr_i == clcr_pkg::OFS_INPUT_BOOST_THRESHOLDS
      && !reg_rst_i && !wr_i |=> rdata_o == $past(wdata_i, 2))
    else $error("06h readback mismatch");
  a_read_valid: assert property ( // see [R5]
    nrst_i |=> rvalid_o == $past(rd_i))
    else $error("read valid out of step");
  a_term_follows: assert property ( // see [R8]
    nrst_i |=> term_en_o == $past(r5[clcr_pkg::TERM_EN_BIT]))
    else $error("termination enable wrong");
  a_wdog_off_quiet: assert property ( // see [R9]
    wdog_sel == 2'b00 [*2] |-> !wdog_exp_q)
    else $error("disabled watchdog expired");
  a_pre_phase: assert property ( // see [R10]
    nrst_i && r5[clcr_pkg::TIMER_EN_BIT]
      |=> pre_phase_h_o == clcr_pkg::PRE_H)
    else $error("pre-charge duration wrong");
  a_fast_duration: assert property ( // see [R11]
    r5[clcr_pkg::TIMER_EN_BIT] && !r5[clcr_pkg::FAST_DUR_BIT]
      |=> fast_phase_h_o == 5'd20)
    else $error("fast phase duration wrong");
  a_therm_limit: assert property ( // see [R12]
    !r5[clcr_pkg::THERM_BIT] |=> thermal_limit_c_o == 7'd90)
    else $error("thermal limit wrong");
  a_warm_cap: assert property ( // see [R13]
    !r5[clcr_pkg::WARM_BIT] |=> warm_voltage_mv_o <= clcr_pkg::WARM_CAP_MV)
    else $error("warm band voltage above cap");
  a_ovp_lowest: assert property ( // see [R14]
    r6[7:6] == 2'b00 |=> input_overvoltage_mv_o == clcr_pkg::OVP_MV_00)
    else $error("input overvoltage threshold wrong");
  a_boost_raw: assert property ( // see [R15]
    nrst_i |=> boost_output_voltage_code_o == $past(r6[5:4]))
    else $error("boost voltage code wrong");
  a_floor_default: assert property ( // see [R16]
    nrst_i && r6[3:0] == 4'h6 |=> input_floor_mv_o == 13'd4500)
    else $error("input floor wrong");
  a_vcode_linear: assert property ( // see [R2]
    r4[7:3] == 5'h1f |=> charge_voltage_mv_o == 13'd4510)
    else $error("top charge voltage wrong");
  a_vcode_default: assert property ( // see [R1]
    nrst_i && r4[7:3] == 5'h08 |=> charge_voltage_mv_o == 13'd4190)
    else $error("default charge voltage wrong");
  a_recharge_high: assert property ( // see [R4]
    r4[clcr_pkg::RECHG_BIT]
      |=> recharge_margin_mv_o == clcr_pkg::RECHG_HI_MV)
    else $error("recharge margin wrong");
  a_final_longest: assert property ( // see [R3]
    r4[2:1] == 2'b11 |=> final_phase_min_o == 6'd45)
    else $error("final phase duration wrong");
endmodule : clcr_bank

// file: design/clcr_store.sv
/*
  Storage of the three configuration bytes with their reset classes.
  Assumes writes and reset strobes arrive as one-cycle pulses.
*/
`timescale 1ns/1ns
module clcr_store (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // Access
  clcr_bus_if.store bus
);
  localparam logic [7:0] RST_VAL [3] = '{
    clcr_pkg::RST_CHARGE_VOLTAGE_LIMIT,
    clcr_pkg::RST_CHARGER_CONTROL_TIMERS,
    clcr_pkg::RST_INPUT_BOOST_THRESHOLDS};
  // Only the two lower bytes fall back when the watchdog expires
  localparam logic [2:0] WDOG_CLASS = 3'b011;

  logic [7:0] reg_q [3];
  logic [7:0] reg_d [3];

  for (genvar g = 0; g < 3; g++) begin : g_reg
    always_comb begin
      reg_d[g] = reg_q[g];
      if (bus.rst_cmd || (bus.wdog_rst && WDOG_CLASS[g])) begin
        reg_d[g] = RST_VAL[g]; // see [R5] see [R6] see [R7]
      end else if (bus.wr_en && bus.wr_idx == 2'(g)) begin
        reg_d[g] = bus.wr_data; // see [R18]
      end
    end
    always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
        reg_q[g] <= RST_VAL[g];
      end else begin
        reg_q[g] <= reg_d[g];
      end
    end
    assign bus.reg_q[g] = reg_q[g];
  end

  a_wdog_keeps_06: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    bus.wdog_rst && !bus.rst_cmd && !bus.wr_en |=> reg_q[2] == $past(reg_q[2]))
    else $error("offset 06h changed on watchdog expiry"); // see [R7]
endmodule : clcr_store

// file: inc/clcr_bus_if.sv
/*
  Byte register access carrier between the register bank and its store.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface clcr_bus_if;
  logic       wr_en;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;
  logic       rst_cmd;
  logic       wdog_rst;
  logic [7:0] reg_q [3];
  modport bank  (output wr_en, wr_idx, wr_data, rst_cmd, wdog_rst,
                 input reg_q);
  modport store (input wr_en, wr_idx, wr_data, rst_cmd, wdog_rst,
                 output reg_q);
endinterface : clcr_bus_if

// file: inc/clcr_pkg.sv
/*
  Package of the charger limit control register bank: offsets, reset
  values, field positions and timing constants.
  Assumes a host-side serial front end that hands over byte accesses.
*/
// What this block does
// [R1] Charge voltage code in 04h bits 7:3, default 01000, low codes listed.
// [R2] Charge voltage codes 01001 to 11111 step 10 mV from 4.290 V.
// [R3] Final phase duration in 04h bits 2:1, 00 off, else 15/30/45 min.
// [R4] 04h bit 0 picks recharge margin: 0 is 120 mV, 1 is 210 mV.
// [R5] 04h reads and writes, resets to 40h, restored by reset command and watchdog.
// [R6] 05h reads and writes, resets to 9Eh, restored by reset command and watchdog.
// [R7] 06h reads and writes, resets to E6h, restored by reset command only.
// [R8] 05h bit 7 enables termination when set, default set.
// [R9] Watchdog period in 05h bits 5:4: off, 40 s, 80 s, 160 s.
// [R10] 05h bit 3 enables both safety timers, pre-charge fixed two hours.
// [R11] 05h bit 2 picks fast phase duration: 0 is 20 h, 1 is 10 h.
// [R12] 05h bit 1 picks thermal limit: 0 is 90 C, 1 is 110 C.
// [R13] 05h bit 0 in warm band: 0 caps at 4.1 V, 1 keeps target.
// [R14] Input overvoltage select in 06h bits 7:6: 5.85, 6.4, 11, 14.2 V.
// [R15] Boost output voltage code in 06h bits 5:4, 00 is 4.6 V.
// [R16] Input voltage floor code in 06h bits 3:0, 3.9 V plus binary weights.
// [R17] Floor bits 1 and 2 weigh 200 mV and 400 mV: plain 100 mV steps.
// [R18] 05h bit 6 stores and reads back, reset 0, no effect; host writes 0.
package clcr_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CHARGE_VOLTAGE_LIMIT   = 8'h04;
  localparam logic [7:0] OFS_CHARGER_CONTROL_TIMERS = 8'h05;
  localparam logic [7:0] OFS_INPUT_BOOST_THRESHOLDS = 8'h06;
  localparam logic [7:0] RST_CHARGE_VOLTAGE_LIMIT   = 8'h40;
  localparam logic [7:0] RST_CHARGER_CONTROL_TIMERS = 8'h9e;
  localparam logic [7:0] RST_INPUT_BOOST_THRESHOLDS = 8'he6;
  localparam logic [7:0] UNMAPPED_READ              = 8'h00;
  localparam int         NUM_REGS                   = 3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int VCODE_LSB      = 3;
  localparam int FINAL_LSB      = 1;
  localparam int RECHG_BIT      = 0;
  localparam int TERM_EN_BIT    = 7;
  localparam int SPARE_BIT      = 6;
  localparam int WDOG_LSB       = 4;
  localparam int TIMER_EN_BIT   = 3;
  localparam int FAST_DUR_BIT   = 2;
  localparam int THERM_BIT      = 1;
  localparam int WARM_BIT       = 0;
  localparam int OVP_LSB        = 6;
  localparam int BOOST_LSB      = 4;
  localparam int FLOOR_LSB      = 0;

  // ----------------------------------------------------------------------
  // Decoded settings, millivolts, minutes, hours and degrees C
  // ----------------------------------------------------------------------
  localparam logic [4:0]  VCODE_LINEAR_FIRST = 5'h09;
  localparam logic [12:0] VLINEAR_BASE_MV    = 13'd4290;
  localparam logic [12:0] VSTEP_MV           = 13'd10;
  localparam logic [12:0] FLOOR_BASE_MV      = 13'd3900;
  localparam logic [12:0] FLOOR_STEP_MV      = 13'd100;
  localparam logic [12:0] WARM_CAP_MV        = 13'd4100;
  localparam logic [7:0]  RECHG_LO_MV        = 8'd120;
  localparam logic [7:0]  RECHG_HI_MV        = 8'd210;
  localparam logic [5:0]  FINAL_STEP_MIN     = 6'd15;
  localparam logic [4:0]  FAST_LONG_H        = 5'd20;
  localparam logic [4:0]  FAST_SHORT_H       = 5'd10;
  localparam logic [4:0]  PRE_H              = 5'd2;
  localparam logic [6:0]  THERM_LO_C         = 7'd90;
  localparam logic [6:0]  THERM_HI_C         = 7'd110;
  localparam logic [13:0] OVP_MV_00          = 14'd5850;
  localparam logic [13:0] OVP_MV_01          = 14'd6400;
  localparam logic [13:0] OVP_MV_10          = 14'd11000;
  localparam logic [13:0] OVP_MV_11          = 14'd14200;
  localparam logic [12:0] BOOST_BASE_MV      = 13'd4600;

  // ----------------------------------------------------------------------
  // Watchdog periods
  // ----------------------------------------------------------------------
  localparam int    CLK_HZ      = 50_000_000;
  localparam int    WDOG_BASE_S = 40;
  localparam longint WDOG_BASE_CYC = longint'(WDOG_BASE_S) * CLK_HZ;
endpackage : clcr_pkg

// file: tb/clcr_bank_tb_top.sv
/*
  Self-checking bench of the charger limit control register bank.
  Assumes a shortened watchdog base count so expiry fits the run.
*/
`timescale 1ns/1ns
module clcr_bank_tb_top;
  localparam longint N = 100;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        wr, rd, rst_cmd, kick, rvalid_o, wdog_expired_o, term_en_o;
  logic        timer_en_o;
  logic [7:0]  addr, wdata, rdata_o, recharge_margin_mv_o, d;
  logic [12:0] charge_voltage_mv_o, warm_voltage_mv_o, input_floor_mv_o;
  logic [5:0]  final_phase_min_o;
  logic [4:0]  pre_phase_h_o, fast_phase_h_o;
  logic [6:0]  thermal_limit_c_o;
  logic [13:0] input_overvoltage_mv_o;
  logic [1:0]  boost_output_voltage_code_o;
  int          failures = 0;
  int          checked  = 0;
  int          c;
  int          low_mv [9] = '{3494, 3590, 3686, 3790, 3894, 3990, 4090,
                              4140, 4190};

  always #10 ref_clk_i = ~ref_clk_i;

  clcr_host_model host (
    .ref_clk_i (ref_clk_i),
    .rdata_i   (rdata_o),
    .rvalid_i  (rvalid_o),
    .wr_o      (wr),
    .rd_o      (rd),
    .addr_o    (addr),
    .wdata_o   (wdata),
    .rst_cmd_o (rst_cmd),
    .kick_o    (kick)
  );

  clcr_bank #(.WDOG_BASE_CYC(N)) dut (
    .ref_clk_i                   (ref_clk_i),
    .nrst_i                      (nrst_i),
    .wr_i                        (wr),
    .rd_i                        (rd),
    .addr_i                      (addr),
    .wdata_i                     (wdata),
    .reg_rst_i                   (rst_cmd),
    .wdog_kick_i                 (kick),
    .rdata_o                     (rdata_o),
    .rvalid_o                    (rvalid_o),
    .wdog_expired_o              (wdog_expired_o),
    .charge_voltage_mv_o         (charge_voltage_mv_o),
    .warm_voltage_mv_o           (warm_voltage_mv_o),
    .final_phase_min_o           (final_phase_min_o),
    .recharge_margin_mv_o        (recharge_margin_mv_o),
    .term_en_o                   (term_en_o),
    .timer_en_o                  (timer_en_o),
    .pre_phase_h_o               (pre_phase_h_o),
    .fast_phase_h_o              (fast_phase_h_o),
    .thermal_limit_c_o           (thermal_limit_c_o),
    .input_overvoltage_mv_o      (input_overvoltage_mv_o),
    .boost_output_voltage_code_o (boost_output_voltage_code_o),
    .input_floor_mv_o            (input_floor_mv_o)
  );

  // --------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Cycles until the expiry flag, counted from the last host request
  task automatic wait_exp(input int lim, output int n);
    n = 0;
    while (n < lim) begin
      @(posedge ref_clk_i);
      #1;
      n++;
      if (wdog_expired_o === 1'b1) break;
    end
  endtask : wait_exp

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset_vals();
    host.read(8'h04, d); check(d, 8'h40);
    host.read(8'h05, d); check(d, 8'h9e);
    host.read(8'h06, d); check(d, 8'he6);
    check(charge_voltage_mv_o, 4190);
    check(warm_voltage_mv_o, 4100);
    check(final_phase_min_o, 0);
    check(recharge_margin_mv_o, 120);
    check({term_en_o, timer_en_o}, 2'b11);
    check({pre_phase_h_o, fast_phase_h_o}, {5'd2, 5'd10});
    check(thermal_limit_c_o, 110);
    check(input_overvoltage_mv_o, 14200);
    check(boost_output_voltage_code_o, 2'h2);
    check(input_floor_mv_o, 4500);
    $display("test reset values done");
  endtask : t_reset_vals

  task automatic t_charge_codes();
    int mv;
    host.write(8'h05, 8'h00);
    for (int k = 0; k < 32; k++) begin
      mv = (k < 9) ? low_mv[k] : 4290 + 10 * (k - 9);
      host.write(8'h04, {k[4:0], k[1:0], k[0]});
      host.read(8'h04, d); check(d, {k[4:0], k[1:0], k[0]});
      check(charge_voltage_mv_o, mv);
      check(warm_voltage_mv_o, (mv > 4100) ? 4100 : mv);
      check(final_phase_min_o, 15 * k[1:0]);
      check(recharge_margin_mv_o, k[0] ? 210 : 120);
    end
    $display("test charge codes done");
  endtask : t_charge_codes

  task automatic t_ctrl_bits();
    host.write(8'h05, 8'h00);
    host.read(8'h05, d); check(d, 8'h00);
    check({term_en_o, timer_en_o}, 2'b00);
    check({pre_phase_h_o, fast_phase_h_o}, 0);
    check(thermal_limit_c_o, 90);
    host.write(8'h05, 8'h0f);
    host.read(8'h05, d); check(d, 8'h0f);
    check({pre_phase_h_o, fast_phase_h_o}, {5'd2, 5'd10});
    check(warm_voltage_mv_o, 4510);
    host.write(8'h05, 8'h8a);
    host.read(8'h05, d); check(d, 8'h8a);
    check(term_en_o, 1'b1);
    check(fast_phase_h_o, 20);
    check(thermal_limit_c_o, 110);
    $display("test control bits done");
  endtask : t_ctrl_bits

  task automatic t_input_thr();
    int input_overvoltage_select [4] = '{5850, 6400, 11000, 14200};
    for (int k = 0; k < 4; k++) begin
      host.write(8'h06, {k[1:0], k[1:0], 4'(15 - 5 * k)});
      host.read(8'h06, d); check(d, {k[1:0], k[1:0], 4'(15 - 5 * k)});
      check(input_overvoltage_mv_o, input_overvoltage_select[k]);
      check(boost_output_voltage_code_o, k[1:0]);
      check(input_floor_mv_o, 3900 + 100 * (15 - 5 * k));
    end
    $display("test input thresholds done");
  endtask : t_input_thr

  task automatic t_unmapped();
    host.write(8'h07, 8'h55);
    host.write(8'h03, 8'haa);
    host.read(8'h07, d); check(d, 8'h00);
    host.read(8'h03, d); check(d, 8'h00);
    host.read(8'h06, d); check(d, 8'hf0);
    host.write_read(8'h06, 8'h3c, d); check(d, 8'h3c);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_reg_cmd();
    host.write(8'h04, 8'h07);
    host.reg_reset();
    host.read(8'h04, d); check(d, 8'h40);
    host.read(8'h05, d); check(d, 8'h9e);
    host.read(8'h06, d); check(d, 8'he6);
    $display("test reset command done");
  endtask : t_reg_cmd

  task automatic t_watchdog();
    host.write(8'h04, 8'hff);
    host.write(8'h06, 8'h00);
    wait_exp(int'(N) + 8, c);
    check(c >= N && c <= N + 4, 1'b1);
    host.read(8'h04, d); check(d, 8'h40);
    host.read(8'h06, d); check(d, 8'h00);
    host.write(8'h05, 8'hae);
    wait_exp(2 * int'(N) + 8, c);
    check(c >= 2 * N && c <= 2 * N + 4, 1'b1);
    host.read(8'h05, d); check(d, 8'h9e);
    for (int k = 0; k < 6; k++) begin
      host.kick();
      wait_exp(int'(N) / 2, c);
      check(wdog_expired_o, 1'b0);
    end
    host.write(8'h05, 8'h8e);
    wait_exp(5 * int'(N), c);
    check(wdog_expired_o, 1'b0);
    $display("test watchdog done");
  endtask : t_watchdog

  // --------------------------------------------------------------------
  // Main sequence and watchdog of the run
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_reset_vals();
    t_charge_codes();
    t_ctrl_bits();
    t_input_thr();
    t_unmapped();
    t_reg_cmd();
    t_watchdog();
    wrap_up();
  end

  initial begin
    #1_000_000;
    failures++;
    wrap_up();
  end
endmodule : clcr_bank_tb_top

// file: tb/clcr_host_model.sv
/*
  Host side model: issues single byte writes, reads and command pulses
  towards the register bank, one request at a time.
  Assumes the bank answers a read with rvalid one cycle after the strobe.
*/
`timescale 1ns/1ns
module clcr_host_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Answer
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  // Requests
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            rst_cmd_o,
  output logic            kick_o
);
  initial begin
    wr_o      = 1'b0;
    rd_o      = 1'b0;
    addr_o    = 8'h00;
    wdata_o   = 8'h00;
    rst_cmd_o = 1'b0;
    kick_o    = 1'b0;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge ref_clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge ref_clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    d = rdata_i;
  endtask : read

  // Write, then read the same offset on the very next edge
  task automatic write_read(input logic [7:0] a, input logic [7:0] wd,
                            output logic [7:0] d);
    @(posedge ref_clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= wd;
    @(posedge ref_clk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b1;
    @(posedge ref_clk_i);
    rd_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~wd;
    #1;
    d = rvalid_i ? rdata_i : ~wd;
  endtask : write_read

  task automatic reg_reset();
    @(posedge ref_clk_i);
    rst_cmd_o <= 1'b1;
    @(posedge ref_clk_i);
    rst_cmd_o <= 1'b0;
  endtask : reg_reset

  task automatic kick();
    @(posedge ref_clk_i);
    kick_o <= 1'b1;
    @(posedge ref_clk_i);
    kick_o <= 1'b0;
  endtask : kick
endmodule : clcr_host_model
